// File: verilog/mgw_pkg.sv
// Purpose: Constants for the gateway frame handler.
// Assumes: Bytes arrive as one-cycle strobes from a UART receiver.
// Notes: Offsets are input register addresses seen over the serial link.
//
// Behaviour
// - First byte is the gateway ID, also for tunnelled relay frames.
// - Second byte is the requested function, or the function answered.
// - Gateway exceptions return the function code with its top bit set.
// - Relay frames use the special code; relay exceptions add 0x80.
// - Third byte of a relay frame is the relay node ID.
// - Fourth byte is the aux code; relay replies add 0x80 to it.
// - Frames end in a two-byte CRC-16, checked before acting.
// - Input read reply: address, 0x04, byte count 2N, values, CRC.
// - Input register 0x0102 holds the count of present relay nodes.
// - Registers 0x0103..0x0105 hold good, bad and unconfigured counts.
// - The special tunnelling function code is 0x44.
// - Special-code frames are only repeated; the gateway never replies.
// - Address 0 is broadcast and gets no reply.
package mgw_pkg;
   localparam logic [7:0] FC_READ_INPUT = 8'h04;
   localparam logic [7:0] FC_SPECIAL = 8'h44;
   localparam logic [7:0] FC_EXC_BIT = 8'h80;
   localparam logic [7:0] ADDR_BROADCAST = 8'h00;
   localparam logic [7:0] ADDR_MAX = 8'hf7;
   localparam logic [15:0] QTY_MIN = 16'h0001;
   localparam logic [15:0] QTY_MAX = 16'h007d;
   localparam logic [15:0] REG_PRESENT = 16'h0102;
   localparam logic [15:0] REG_GOOD = 16'h0103;
   localparam logic [15:0] REG_BAD = 16'h0104;
   localparam logic [15:0] REG_UNCONF = 16'h0105;
   localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
   localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
   localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'ha001;
   localparam logic [7:0] REQ_LEN = 8'h08;
   localparam logic [7:0] DEF_GW_ID = 8'h01;
endpackage : mgw_pkg

// File: verilog/mgw_crc_if.sv
`timescale 1ns/1ns
// Purpose: Carries byte strobes between the handler and its CRC engine.
// Assumes: One byte per strobe.
// Notes: Clear and strobe must not meet in one cycle.
interface mgw_crc_if;
   logic clr;
   logic stb;
   logic [7:0] data;
   logic [15:0] crc;
   modport master (output clr, output stb, output data, input crc);
   modport engine (input clr, input stb, input data, output crc);
endinterface : mgw_crc_if

// File: verilog/mgw_crc16.sv
`timescale 1ns/1ns
// Purpose: Byte-wide CRC-16 with the reflected serial-bus polynomial.
// Assumes: Clear precedes each frame.
// Notes: Result is low byte first on the wire.
module mgw_crc16 (
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   mgw_crc_if.engine crc_bus
);
   logic [15:0] crc_q;

   function automatic logic [15:0] mgw_step(input logic [15:0] c,
                                            input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ mgw_pkg::CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : mgw_step

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         crc_q <= mgw_pkg::CRC_INIT;
      end else if (crc_bus.clr) begin
         crc_q <= mgw_pkg::CRC_INIT;
      end else if (crc_bus.stb) begin
         crc_q <= mgw_step(crc_q, crc_bus.data);
      end
   end
   assign crc_bus.crc = crc_q;
endmodule : mgw_crc16

// File: verilog/mgw_frame_handler.sv
`timescale 1ns/1ns
// Purpose: Gateway frame handler: answers input reads, repeats relay frames.
// Assumes: i_rx_* are bytes from the master, i_frame_end marks a gap.
// Notes: Tx bytes leave one per i_tx_ready handshake.
module mgw_frame_handler (
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   input wire logic [7:0] i_gw_id,
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_data,
   input wire logic i_frame_end,
   input wire logic [15:0] i_present_node_count,
   input wire logic [15:0] i_good_config_node_count,
   input wire logic [15:0] i_bad_config_node_count,
   input wire logic [15:0] i_unconfigured_node_count,
   input wire logic i_tx_ready,
   output logic o_tx_valid,
   output logic [7:0] o_tx_data,
   output logic o_relay_valid,
   output logic [7:0] o_relay_data,
   output logic o_crc_error
);
   // ***************************************************************
   // Receive side
   // ***************************************************************
   typedef enum logic [2:0] {ST_RX, ST_CHECK, ST_TX, ST_WAIT} mgw_state_e;
   mgw_state_e state_q;
   logic [7:0] buf_q [8];
   logic [7:0] cnt_q;
   logic relay_q;
   logic [15:0] crc_at_q;
   mgw_crc_if crc_bus ();

   mgw_crc16 u_crc (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .crc_bus(crc_bus)
   );

   // Bytes of every frame received in ST_RX go straight out
   // with one cycle of latency, so the relay chain sees them unaltered.
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_relay_valid <= 1'b0;
         o_relay_data <= 8'h00;
      end else begin
         o_relay_valid <= i_rx_valid && state_q == ST_RX;
         o_relay_data <= i_rx_data;
      end
   end

   // Once the second byte shows the special code, the frame is repeated
   // and buffered, but the gateway will not reply to it. The mark must
   // survive into the check cycle, which is where it blocks the reply.
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         relay_q <= 1'b0;
      end else if (state_q == ST_CHECK) begin
         relay_q <= 1'b0;
      end else if (i_rx_valid && state_q == ST_RX && cnt_q == 8'h01) begin
         relay_q <= i_rx_data == mgw_pkg::FC_SPECIAL;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt_q <= 8'h00;
         crc_at_q <= 16'h0000;
         for (int i = 0; i < 8; i++) begin
            buf_q[i] <= 8'h00;
         end
      end else if (state_q == ST_RX && i_rx_valid) begin
         // The count is kept past the frame end, since the check cycle
         // judges the frame length from it.
         if (cnt_q < mgw_pkg::REQ_LEN) begin
            buf_q[cnt_q[2:0]] <= i_rx_data;
         end
         if (cnt_q != 8'hff) begin
            cnt_q <= cnt_q + 8'h01;
         end
         // Keep the CRC of the body, i.e. before the two trailer bytes.
         if (cnt_q == mgw_pkg::REQ_LEN - 8'h02) begin
            crc_at_q <= crc_bus.crc;
         end
      end else if (state_q == ST_CHECK) begin
         cnt_q <= 8'h00;
      end
   end

   // ***************************************************************
   // Request decode
   // ***************************************************************
   logic [15:0] start_w;
   logic [15:0] qty_w;
   logic [15:0] last_w;
   logic crc_ok_w;
   logic for_me_w;
   logic fc_ok_w;
   logic qty_ok_w;
   logic addr_ok_w;
   assign start_w = {buf_q[2], buf_q[3]};
   assign qty_w = {buf_q[4], buf_q[5]};
   assign last_w = start_w + qty_w - 16'h0001;
   assign crc_ok_w = {buf_q[7], buf_q[6]} == crc_at_q;
   assign for_me_w = buf_q[0] == i_gw_id;
   assign fc_ok_w = buf_q[1] == mgw_pkg::FC_READ_INPUT;
   assign qty_ok_w = qty_w >= mgw_pkg::QTY_MIN
                     && qty_w <= mgw_pkg::QTY_MAX;
   assign addr_ok_w = start_w >= mgw_pkg::REG_PRESENT
                      && last_w <= mgw_pkg::REG_UNCONF
                      && last_w >= start_w;

   // ***************************************************************
   // Reply assembly
   // ***************************************************************
   logic [7:0] rsp_q [13];
   logic [3:0] rlen_q;
   logic [3:0] ridx_q;
   logic crc_phase_q;

   function automatic logic [15:0] mgw_reg(input logic [15:0] a,
                                           input logic [15:0] p,
                                           input logic [15:0] g,
                                           input logic [15:0] b,
                                           input logic [15:0] u);
      logic [15:0] v;
      v = 16'h0000;
      unique case (a)
         mgw_pkg::REG_PRESENT: v = p;
         mgw_pkg::REG_GOOD: v = g;
         mgw_pkg::REG_BAD: v = b;
         mgw_pkg::REG_UNCONF: v = u;
         default: v = 16'h0000;
      endcase
      return v;
   endfunction : mgw_reg

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         rlen_q <= 4'h0;
         for (int i = 0; i < 13; i++) begin
            rsp_q[i] <= 8'h00;
         end
      end else if (state_q == ST_CHECK) begin
         rsp_q[0] <= i_gw_id;
         if (!fc_ok_w) begin
            rsp_q[1] <= buf_q[1] | mgw_pkg::FC_EXC_BIT;
            rsp_q[2] <= mgw_pkg::EXC_ILLEGAL_FUNC;
            rlen_q <= 4'h3;
         end else if (!qty_ok_w) begin
            rsp_q[1] <= buf_q[1] | mgw_pkg::FC_EXC_BIT;
            rsp_q[2] <= mgw_pkg::EXC_ILLEGAL_VALUE;
            rlen_q <= 4'h3;
         end else if (!addr_ok_w) begin
            rsp_q[1] <= buf_q[1] | mgw_pkg::FC_EXC_BIT;
            rsp_q[2] <= mgw_pkg::EXC_ILLEGAL_ADDR;
            rlen_q <= 4'h3;
         end else begin
            rsp_q[1] <= mgw_pkg::FC_READ_INPUT;
            rsp_q[2] <= {qty_w[6:0], 1'b0};
            for (int i = 0; i < 4; i++) begin
               rsp_q[3 + 2 * i] <= 8'(mgw_reg(start_w + 16'(i),
                  i_present_node_count, i_good_config_node_count,
                  i_bad_config_node_count,
                  i_unconfigured_node_count) >> 8);
               rsp_q[4 + 2 * i] <= 8'(mgw_reg(start_w + 16'(i),
                  i_present_node_count, i_good_config_node_count,
                  i_bad_config_node_count, i_unconfigured_node_count));
            end
            rlen_q <= 4'(3 + 2 * qty_w[2:0]);
         end
      end
   end

   // ***************************************************************
   // Control and transmit
   // ***************************************************************
   logic take_w;
   assign take_w = !relay_q && cnt_q == mgw_pkg::REQ_LEN && crc_ok_w
                   && for_me_w && buf_q[0] != mgw_pkg::ADDR_BROADCAST;

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         state_q <= ST_RX;
      end else begin
         unique case (state_q)
            ST_RX: if (i_frame_end) begin
               state_q <= ST_CHECK;
            end
            ST_CHECK: state_q <= take_w ? ST_TX : ST_RX;
            ST_TX: if (crc_phase_q && ridx_q == 4'h1 && i_tx_ready
                       && o_tx_valid) begin
               state_q <= ST_WAIT;
            end
            ST_WAIT: state_q <= ST_RX;
         endcase
      end
   end

   // A frame end is only honoured in ST_RX; a fresh frame arriving while
   // a reply is still going out is not buffered. Half duplex makes that
   // impossible on a correct bus.
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_crc_error <= 1'b0;
      end else begin
         o_crc_error <= state_q == ST_CHECK && cnt_q == mgw_pkg::REQ_LEN
                        && !relay_q && !crc_ok_w;
      end
   end

   logic [15:0] tx_crc_q;
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_tx_valid <= 1'b0;
         o_tx_data <= 8'h00;
         ridx_q <= 4'h0;
         crc_phase_q <= 1'b0;
         tx_crc_q <= 16'h0000;
      end else if (state_q == ST_CHECK) begin
         ridx_q <= 4'h0;
         crc_phase_q <= 1'b0;
         o_tx_valid <= 1'b0;
      end else if (state_q == ST_TX) begin
         if (!o_tx_valid || i_tx_ready) begin
            if (!crc_phase_q && ridx_q < rlen_q) begin
               o_tx_valid <= 1'b1;
               o_tx_data <= rsp_q[ridx_q];
               ridx_q <= ridx_q + 4'h1;
            end else if (!crc_phase_q) begin
               // Last data byte is in the engine now; low byte first.
               o_tx_valid <= 1'b1;
               o_tx_data <= crc_bus.crc[7:0];
               tx_crc_q <= crc_bus.crc;
               crc_phase_q <= 1'b1;
               ridx_q <= 4'h0;
            end else if (ridx_q == 4'h0) begin
               o_tx_data <= tx_crc_q[15:8];
               ridx_q <= 4'h1;
            end else begin
               o_tx_valid <= 1'b0;
            end
         end
      end else begin
         o_tx_valid <= 1'b0;
      end
   end

   // The single engine serves both directions; it restarts at the start
   // of each received frame and again before the reply.
   always_comb begin
      crc_bus.clr = state_q == ST_CHECK || (state_q == ST_RX && cnt_q == 8'h00
                    && !i_rx_valid);
      crc_bus.stb = (state_q == ST_RX && i_rx_valid)
                    || (state_q == ST_TX && !crc_phase_q
                        && ridx_q < rlen_q && (!o_tx_valid || i_tx_ready));
      crc_bus.data = state_q == ST_TX ? rsp_q[ridx_q] : i_rx_data;
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   // Bytes taken by the sink in the current reply. The sink may stall
   // for any time, so the reply is judged by length, not by duration.
   logic [3:0] tx_acc_q;
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         tx_acc_q <= 4'h0;
      end else if (state_q == ST_CHECK) begin
         tx_acc_q <= 4'h0;
      end else if (o_tx_valid && i_tx_ready) begin
         tx_acc_q <= tx_acc_q + 4'h1;
      end
   end

   a_relay_no_reply: assert property (
      @(posedge i_clk_sys) disable iff (!i_resetn)
      state_q == ST_CHECK && relay_q |=> state_q == ST_RX)
      else $error("Reply to relay frame.");
   a_broadcast_silent: assert property (
      @(posedge i_clk_sys) disable iff (!i_resetn)
      state_q == ST_CHECK && buf_q[0] == mgw_pkg::ADDR_BROADCAST
      |=> !o_tx_valid [*2])
      else $error("Reply to broadcast.");
   a_first_byte_id: assert property (
      @(posedge i_clk_sys) disable iff (!i_resetn)
      $rose(o_tx_valid) && state_q == ST_TX && ridx_q == 4'h1
      && !crc_phase_q |-> o_tx_data == i_gw_id)
      else $error("First reply byte is not the ID.");
   a_exc_code_msb: assert property (
      @(posedge i_clk_sys) disable iff (!i_resetn)
      state_q == ST_CHECK && take_w && !fc_ok_w
      |=> rsp_q[1][7] && rlen_q == 4'h3)
      else $error("Exception without top bit.");
   a_byte_count: assert property (
      @(posedge i_clk_sys) disable iff (!i_resetn)
      state_q == ST_CHECK && take_w && fc_ok_w && qty_ok_w && addr_ok_w
      |=> rsp_q[2] == 8'($past(qty_w) * 2))
      else $error("Byte count is not twice N.");
   a_bad_crc_drop: assert property (
      @(posedge i_clk_sys) disable iff (!i_resetn)
      state_q == ST_CHECK && !crc_ok_w |=> state_q == ST_RX)
      else $error("Acted on bad CRC.");
   a_qty_range: assert property (
      @(posedge i_clk_sys) disable iff (!i_resetn)
      state_q == ST_CHECK && take_w && fc_ok_w && !qty_ok_w
      |=> rsp_q[2] == mgw_pkg::EXC_ILLEGAL_VALUE)
      else $error("Bad quantity not refused.");
   a_reply_bounded: assert property (
      @(posedge i_clk_sys) disable iff (!i_resetn)
      state_q == ST_WAIT && rsp_q[1][7] |-> tx_acc_q == 4'h5)
      else $error("Error reply length is not five bytes.");
   c_good_read: cover property (@(posedge i_clk_sys) state_q == ST_CHECK
      && take_w && addr_ok_w && qty_ok_w && fc_ok_w);
   c_exception: cover property (@(posedge i_clk_sys) state_q == ST_CHECK
      && take_w && !fc_ok_w);
   c_relay: cover property (@(posedge i_clk_sys) o_relay_valid && relay_q);
endmodule : mgw_frame_handler

// File: testbench/mgw_master_model.sv
// Purpose: Serial master model that feeds request bytes to the handler.
// Assumes: Bytes go out at falling edges, one idle cycle between them.
// Notes: The sink side stalls at random to stretch replies.
`timescale 1ns/1ns
module mgw_master_model (
   input wire logic i_clk,
   output logic o_rx_valid,
   output logic [7:0] o_rx_data,
   output logic o_frame_end,
   output logic o_tx_ready
);
   initial begin
      o_rx_valid = 1'b0;
      o_rx_data = 8'h00;
      o_frame_end = 1'b0;
      o_tx_ready = 1'b0;
   end

   // Random stalls show that reply bytes stand until taken.
   always @(negedge i_clk) begin
      o_tx_ready <= ($urandom % 3) != 0;
   end

   // The caller hands over whole frames, CRC trailer included.
   task automatic send(input logic [7:0] f[$]);
      foreach (f[i]) begin
         @(negedge i_clk);
         o_rx_valid = 1'b1;
         o_rx_data = f[i];
         @(negedge i_clk);
         o_rx_valid = 1'b0;
         // A stale byte would hide a late sample, so show its inverse.
         o_rx_data = ~f[i];
      end
      @(negedge i_clk);
      o_frame_end = 1'b1;
      @(negedge i_clk);
      o_frame_end = 1'b0;
   endtask : send
endmodule : mgw_master_model

// File: testbench/tb_mgw_frame_handler.sv
// Purpose: Self-checking bench for the gateway frame handler.
// Assumes: Replies and relay copies are checked in order by a monitor.
// Notes: Expected bytes are built here, CRC included.
`timescale 1ns/1ns
module tb_mgw_frame_handler;
   logic clk = 1'b0;
   logic i_resetn = 1'b0;
   logic [7:0] gw = mgw_pkg::DEF_GW_ID;
   logic [15:0] cnt [4];
   logic rx_valid, frame_end, tx_ready, o_tx_valid, o_relay_valid;
   logic [7:0] rx_data, o_tx_data, o_relay_data;
   logic o_crc_error;
   logic [7:0] exp_q[$], rel_q[$];
   int fail_count = 0;
   int n_tests = 0;
   int crc_cnt = 0;
   int cyc = 0;

   always #2 clk = ~clk;

   mgw_master_model mgw_master_model_i (.i_clk(clk), .o_rx_valid(rx_valid),
      .o_rx_data(rx_data), .o_frame_end(frame_end), .o_tx_ready(tx_ready));

   mgw_frame_handler mgw_frame_handler_i (.i_clk_sys(clk),
      .i_resetn(i_resetn), .i_gw_id(gw), .i_rx_valid(rx_valid),
      .i_rx_data(rx_data), .i_frame_end(frame_end),
      .i_present_node_count(cnt[0]), .i_good_config_node_count(cnt[1]),
      .i_bad_config_node_count(cnt[2]),
      .i_unconfigured_node_count(cnt[3]), .i_tx_ready(tx_ready),
      .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
      .o_relay_valid(o_relay_valid), .o_relay_data(o_relay_data),
      .o_crc_error(o_crc_error));

   // ********************************************************************
   // Checking
   // ********************************************************************
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic print_verdict;
      if (fail_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : print_verdict

   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         fail_count++;
         print_verdict();
      end
      if (i_resetn) begin
         if (o_tx_valid && tx_ready) begin
            if (exp_q.size() == 0) begin
               chk("tx_extra", 16'h0100, {8'h00, o_tx_data});
            end else begin
               chk("tx_data", {8'h00, exp_q.pop_front()},
                   {8'h00, o_tx_data});
            end
         end
         if (o_relay_valid) begin
            if (rel_q.size() == 0) begin
               chk("relay_extra", 16'h0100,
                   {8'h00, o_relay_data});
            end else begin
               chk("relay_data", {8'h00, rel_q.pop_front()},
                   {8'h00, o_relay_data});
            end
         end
         if (o_crc_error) begin
            crc_cnt++;
         end
      end
   end

   // ********************************************************************
   // Stimulus
   // ********************************************************************
   function automatic logic [15:0] crc(input logic [7:0] f[$]);
      logic [15:0] c;
      c = mgw_pkg::CRC_INIT;
      foreach (f[i]) begin
         c = c ^ {8'h00, f[i]};
         for (int b = 0; b < 8; b++) begin
            c = c[0] ? ((c >> 1) ^ mgw_pkg::CRC_POLY) : (c >> 1);
         end
      end
      return c;
   endfunction : crc

   task automatic go(input logic [7:0] f[$], input logic [7:0] r[$],
                     input bit bad);
      logic [15:0] c;
      c = crc(f);
      f.push_back(c[7:0]);
      f.push_back(c[15:8]);
      if (bad) begin
         f[f.size() - 1] = f[f.size() - 1] ^ 8'h5a;
      end
      foreach (f[i]) rel_q.push_back(f[i]);
      if (r.size() != 0) begin
         c = crc(r);
         r.push_back(c[7:0]);
         r.push_back(c[15:8]);
      end
      foreach (r[i]) exp_q.push_back(r[i]);
      mgw_master_model_i.send(f);
      for (int k = 0; k < 3000 && (exp_q.size() != 0 || o_tx_valid !== 1'b0);
           k++) begin
         @(negedge clk);
      end
      repeat (6) @(negedge clk);
      chk("tx_left", 16'h0000, 16'(exp_q.size()));
      chk("relay_left", 16'h0000, 16'(rel_q.size()));
   endtask : go

   task automatic rd(input logic [15:0] a, input logic [15:0] q);
      logic [7:0] r[$];
      logic [7:0] ef;
      int s;
      ef = mgw_pkg::FC_READ_INPUT | mgw_pkg::FC_EXC_BIT;
      s = int'(a) - int'(mgw_pkg::REG_PRESENT);
      r = '{gw, mgw_pkg::FC_READ_INPUT};
      if (q < mgw_pkg::QTY_MIN || q > mgw_pkg::QTY_MAX) begin
         r = '{gw, ef, mgw_pkg::EXC_ILLEGAL_VALUE};
      end else if (s < 0 || s + int'(q) > 4) begin
         r = '{gw, ef, mgw_pkg::EXC_ILLEGAL_ADDR};
      end else begin
         r.push_back(8'(q * 2));
         for (int k = 0; k < int'(q); k++) begin
            r.push_back(cnt[s + k][15:8]);
            r.push_back(cnt[s + k][7:0]);
         end
      end
      go('{gw, mgw_pkg::FC_READ_INPUT, a[15:8], a[7:0], q[15:8], q[7:0]},
         r, 1'b0);
   endtask : rd

   initial begin
      logic [7:0] fcs [3];
      fcs = '{8'h03, 8'h06, 8'h10};
      void'($urandom(32'hc36e));
      foreach (cnt[k]) cnt[k] = 16'($urandom);
      repeat (20) @(negedge clk);
      i_resetn = 1'b1;
      @(negedge clk);
      rd(16'h0102, 16'h0004);
      rd(16'h0105, 16'h0001);
      rd(16'h0102, 16'h0000);
      rd(16'h0102, 16'h007d);
      rd(16'h0234, 16'h0002);
      foreach (fcs[i]) begin
         go('{gw, fcs[i], 8'h00, 8'h00, 8'h00, 8'h01},
            '{gw, fcs[i] | mgw_pkg::FC_EXC_BIT, mgw_pkg::EXC_ILLEGAL_FUNC},
            1'b0);
      end
      go('{8'h00, 8'h04, 8'h01, 8'h02, 8'h00, 8'h04}, '{},
         1'b0);
      go('{gw + 8'h01, 8'h04, 8'h01, 8'h02, 8'h00, 8'h04}, '{},
         1'b0);
      go('{gw, mgw_pkg::FC_SPECIAL, 8'h05, 8'h04, 8'h01, 8'h02, 8'h00,
           8'h01}, '{}, 1'b0);
      // Eight bytes pass the length check, so the relay mark keeps the gateway
      // silent here with good CRC, and keeps o_crc_error low with bad.
      go('{gw, mgw_pkg::FC_SPECIAL, 8'h05, 8'h04, 8'h01, 8'h02}, '{},
         1'b0);
      go('{gw, mgw_pkg::FC_SPECIAL, 8'h05, 8'h04, 8'h01, 8'h02}, '{},
         1'b1);
      go('{gw, 8'h04, 8'h01, 8'h02, 8'h00}, '{}, 1'b0);
      chk("crc_error", 16'h0000, 16'(crc_cnt));
      go('{gw, 8'h04, 8'h01, 8'h02, 8'h00, 8'h04}, '{},
         1'b1);
      chk("crc_error", 16'h0001, 16'(crc_cnt));
      gw = 8'h01 + 8'($urandom % 247);
      foreach (cnt[k]) cnt[k] = 16'($urandom);
      rd(16'h0103, 16'h0003);
      print_verdict();
   end
endmodule : tb_mgw_frame_handler
